// [rtl/fsh_fault_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fsh_params.svh"

// Overview of operation
// RULE1: Handler control bit 7 shows and sets the supervisor call active state.
// RULE2: Handler control bit 3 shows and sets the usage fault active state.
// RULE3: Handler control bit 1 shows bus fault active, resets zero, writable.
// RULE4: Handler control bit 0 shows memory fault active, resets zero, writable.
// RULE5: Handler control bits 6:4 and 2 are reserved and read zero.
// RULE6: Fault status register is reachable only by privileged accesses.
// RULE7: Usage causes in bits 31:16, bus 15:8, memory 7:0.
// RULE8: Word access at 0xD28 reaches the whole fault status register.
// RULE9: Byte access at 0xD28 reaches only the memory fault byte.
// RULE10: Halfword access at 0xD28 reaches memory and bus bytes together.
// RULE11: Byte access at 0xD29 reaches only the bus fault byte.
// RULE12: Halfword access at 0xD2A reaches only the usage fault half.
// RULE13: Writing one clears a status bit; writing zero leaves it.
// RULE14: Handlers read the fault address before its valid flag.
// RULE15: Memory and bus bytes each hold an address-valid flag.
// RULE16: A later fault may overwrite a fault address and its valid flag.
// RULE17: Hardware fault set beats a software clear in the same cycle.
module fsh_fault_regs (
  input wire logic clk,
  input wire logic rst,
  input wire fsh_pkg::fsh_req_t req,
  input wire fsh_pkg::fsh_fault_t fault,
  input wire fsh_pkg::fsh_active_t active_set,
  input wire fsh_pkg::fsh_active_t active_clr,
  output logic [31:0] rdata,
  output logic ready,
  output logic access_error,
  output fsh_pkg::fsh_active_t active,
  output logic [31:0] memory_fault_address,
  output logic [31:0] bus_fault_address
);

  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ready_reg;
  logic err_reg;
  logic err_next;
  logic [3:0] act_reg;
  logic [3:0] act_next;
  logic [31:0] maddr_reg;
  logic [31:0] baddr_reg;

  // Byte lane enables for the fault status word, by offset and size
  function automatic logic [3:0] stat_lanes(input logic [11:0] ofs,
                                            input fsh_pkg::fsh_size_t sz);
    logic [3:0] lanes;
    lanes = 4'h0;
    if (ofs == `FSH_FAULT_STAT_OFS && sz == fsh_pkg::FSH_SIZE_WORD) begin
      lanes = 4'hF; // RULE8
    end else if (ofs == `FSH_FAULT_STAT_OFS && sz == fsh_pkg::FSH_SIZE_HALF) begin
      lanes = 4'h3; // RULE10
    end else if (ofs == `FSH_FAULT_STAT_OFS && sz == fsh_pkg::FSH_SIZE_BYTE) begin
      lanes = 4'h1; // RULE9
    end else if (ofs == `FSH_BUS_STAT_OFS && sz == fsh_pkg::FSH_SIZE_BYTE) begin
      lanes = 4'h2; // RULE11
    end else if (ofs == `FSH_USAGE_STAT_OFS && sz == fsh_pkg::FSH_SIZE_HALF) begin
      lanes = 4'hC; // RULE12
    end
    return lanes;
  endfunction

  // Expand lane enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] lanes);
    return {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
  endfunction

  // Request decode
  wire [3:0] lanes = stat_lanes(req.offset, req.size);
  wire stat_hit = lanes != 4'h0;
  wire ctrl_hit = req.offset == `FSH_HANDLER_CTRL_OFS && req.size == fsh_pkg::FSH_SIZE_WORD;
  wire allowed = req.valid && req.privileged; // RULE6
  wire stat_wr = allowed && req.write && stat_hit;
  wire ctrl_wr = allowed && req.write && ctrl_hit;
  wire [31:0] sel_mask = lane_mask(lanes);
  // Write data lands on the lanes of the addressed subregister
  wire [31:0] wdata_lane = (req.offset == `FSH_BUS_STAT_OFS) ? {16'h0000, req.wdata[7:0], 8'h00} :
                           (req.offset == `FSH_USAGE_STAT_OFS) ? {req.wdata[15:0], 16'h0000} :
                           req.wdata;
  wire [31:0] clr_bits = stat_wr ? (wdata_lane & sel_mask) : 32'h0000_0000; // RULE13
  wire [31:0] hw_set = fault.cause_set & `FSH_FAULT_STAT_MASK;
  // Valid flags follow the address loads
  wire [31:0] valid_set = {16'h0000, fault.bus_addr_load, 7'h00, fault.mem_addr_load, 7'h00}; // RULE15
  // Read view shifted down so the subregister sits in the low bits
  wire [31:0] stat_view = stat_reg & sel_mask;
  wire [31:0] stat_rd = (req.offset == `FSH_BUS_STAT_OFS) ? {24'h00_0000, stat_view[15:8]} :
                        (req.offset == `FSH_USAGE_STAT_OFS) ? {16'h0000, stat_view[31:16]} :
                        stat_view; // RULE7
  wire [31:0] ctrl_rd = {24'h00_0000, act_reg[3], 3'b000, act_reg[2], 1'b0,
                         act_reg[1], act_reg[0]}; // RULE5

  // Status update: set has priority over clear
  assign stat_next = ((stat_reg & ~clr_bits) | hw_set | valid_set) & `FSH_FAULT_STAT_MASK; // RULE17

  // Active flags: software write, then hardware clear, then hardware set
  wire [3:0] act_sw = ctrl_wr ? {req.wdata[`FSH_SVC_ACTIVE_BIT], req.wdata[`FSH_USAGE_ACTIVE_BIT],
                                 req.wdata[`FSH_BUS_ACTIVE_BIT], req.wdata[`FSH_MEM_ACTIVE_BIT]}
                              : act_reg; // RULE1 RULE2 RULE3 RULE4
  assign act_next = (act_sw & ~active_clr) | active_set;

  // Read data and error
  assign rdata_next = !(allowed && !req.write) ? 32'h0000_0000 :
                      stat_hit ? stat_rd :
                      ctrl_hit ? ctrl_rd : 32'h0000_0000;
  assign err_next = req.valid && (!req.privileged || !(stat_hit || ctrl_hit)); // RULE6

  // Status and active registers
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_reg <= `FSH_FAULT_STAT_RESET;
      act_reg <= 4'(`FSH_HANDLER_RESET); // Only the four active flags are stored
    end else begin
      stat_reg <= stat_next;
      act_reg <= act_next;
    end
  end

  // Fault address capture, a later fault overwrites
  always_ff @(posedge clk) begin
    if (rst) begin
      maddr_reg <= 32'h0000_0000;
      baddr_reg <= 32'h0000_0000;
    end else begin
      if (fault.mem_addr_load) begin
        maddr_reg <= fault.mem_addr; // RULE16
      end
      if (fault.bus_addr_load) begin
        baddr_reg <= fault.bus_addr; // RULE16
      end
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ready_reg <= req.valid;
      err_reg <= err_next;
    end
  end

  assign rdata = rdata_reg;
  assign ready = ready_reg;
  assign access_error = err_reg;
  assign active = act_reg;
  assign memory_fault_address = maddr_reg;
  assign bus_fault_address = baddr_reg;

endmodule
`default_nettype wire

// [shared/fsh_params.svh]
`ifndef FSH_PARAMS_SVH
`define FSH_PARAMS_SVH

// Register offsets inside the system control space
`define FSH_HANDLER_CTRL_OFS 12'hD24
`define FSH_FAULT_STAT_OFS 12'hD28
`define FSH_BUS_STAT_OFS 12'hD29
`define FSH_USAGE_STAT_OFS 12'hD2A

// Handler control active bit positions
`define FSH_SVC_ACTIVE_BIT 7
`define FSH_USAGE_ACTIVE_BIT 3
`define FSH_BUS_ACTIVE_BIT 1
`define FSH_MEM_ACTIVE_BIT 0

// Address-valid flag positions inside each status byte
`define FSH_MEM_ADDR_VALID_BIT 7
`define FSH_BUS_ADDR_VALID_BIT 15

// Reset values
`define FSH_FAULT_STAT_RESET 32'h0000_0000
`define FSH_HANDLER_RESET 8'h00

// Implemented bits of the fault status word, reserved bits read zero
`define FSH_FAULT_STAT_MASK 32'h030F_BFBB

`endif

// [shared/fsh_pkg.sv]
package fsh_pkg;

  // Access size on the internal register bus
  typedef enum logic [1:0] {
    FSH_SIZE_BYTE,
    FSH_SIZE_HALF,
    FSH_SIZE_WORD
  } fsh_size_t;

  // One register bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic privileged;
    fsh_size_t size;
    logic [11:0] offset;
    logic [31:0] wdata;
  } fsh_req_t;

  // Hardware fault events
  typedef struct packed {
    logic [31:0] cause_set;
    logic mem_addr_load;
    logic [31:0] mem_addr;
    logic bus_addr_load;
    logic [31:0] bus_addr;
  } fsh_fault_t;

  // Active flags of the handler control low byte
  typedef struct packed {
    logic svc;
    logic usage;
    logic bus;
    logic mem;
  } fsh_active_t;

endpackage

// [tb/fsh_fault_checker.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fsh_params.svh"
module fsh_fault_checker (
  input wire logic clk,
  input wire logic rst,
  input wire fsh_pkg::fsh_req_t req,
  input wire fsh_pkg::fsh_fault_t fault,
  input wire fsh_pkg::fsh_active_t active_set,
  input wire fsh_pkg::fsh_active_t active_clr,
  input wire logic [31:0] rdata,
  input wire logic ready,
  input wire logic access_error,
  input wire fsh_pkg::fsh_active_t active,
  input wire logic [31:0] memory_fault_address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Privileged reads, a clean handler write and its flag image
  wire logic rd = req.valid && req.privileged && !req.write;
  wire logic hw = req.valid && req.privileged && req.write && req.offset == `FSH_HANDLER_CTRL_OFS
    && req.size == fsh_pkg::FSH_SIZE_WORD && active_set == 4'h0 && active_clr == 4'h0;
  wire fsh_pkg::fsh_active_t wa = {req.wdata[7], req.wdata[3], req.wdata[1], req.wdata[0]};
  unpriv_refused_a: assert property (req.valid && !req.privileged |=> access_error)
    else $error("unprivileged access not refused");
  svc_set_a: assert property (active_set.svc |=> active.svc)
    else $error("svc active not set");
  active_write_a: assert property (hw |=> active == $past(wa))
    else $error("active flags not written");
  ctrl_reserved_a: assert property (rd && req.offset == `FSH_HANDLER_CTRL_OFS |=>
    (rdata & 32'hFFFF_FF74) == 32'h0000_0000) else $error("reserved handler bits not zero");
  stat_mask_a: assert property (rd && req.offset == `FSH_FAULT_STAT_OFS |=>
    (rdata & ~`FSH_FAULT_STAT_MASK) == 32'h0000_0000) else $error("reserved status bits set");
  mem_byte_a: assert property (rd && req.offset == `FSH_FAULT_STAT_OFS &&
    req.size == fsh_pkg::FSH_SIZE_BYTE |=> rdata[31:8] == 24'h00_0000) else $error("byte wide");
  usage_half_a: assert property (rd && req.offset == `FSH_USAGE_STAT_OFS |=>
    rdata[31:16] == 16'h0000) else $error("usage half not right-justified");
  mem_addr_a: assert property (fault.mem_addr_load |=>
    memory_fault_address == $past(fault.mem_addr)) else $error("fault address not captured");
  // Main scenarios
  cover property (hw);
  cover property (req.valid && !req.privileged);
  cover property (fault.mem_addr_load);
endmodule
bind fsh_fault_regs fsh_fault_checker chk (.clk(clk), .rst(rst), .req(req), .fault(fault),
  .active_set(active_set), .active_clr(active_clr), .rdata(rdata), .ready(ready),
  .access_error(access_error), .active(active), .memory_fault_address(memory_fault_address));
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam fsh_pkg::fsh_size_t sb = fsh_pkg::FSH_SIZE_BYTE;
  localparam fsh_pkg::fsh_size_t sh = fsh_pkg::FSH_SIZE_HALF;
  localparam fsh_pkg::fsh_size_t sw = fsh_pkg::FSH_SIZE_WORD;
  logic clk, rst, ready, access_error;
  logic [31:0] rdata, memory_fault_address, bus_fault_address;
  fsh_pkg::fsh_req_t req;
  fsh_pkg::fsh_fault_t fault;
  fsh_pkg::fsh_active_t active_set, active_clr, active;
  int errors, num_checks, cycles;
  fsh_fault_regs dut (.clk(clk), .rst(rst), .req(req), .fault(fault), .active_set(active_set),
    .active_clr(active_clr), .rdata(rdata), .ready(ready), .access_error(access_error),
    .active(active), .memory_fault_address(memory_fault_address),
    .bus_fault_address(bus_fault_address));
  // Compares a seen value with the expected one
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access, answer judged in the single cycle it stands
  task automatic acc(input logic [1:0] wp, input fsh_pkg::fsh_size_t s, input logic [11:0] o,
    input logic [31:0] d, input logic [31:0] e, input logic x);
    req = '{1'b1, wp[1], wp[0], s, o, d};
    @(negedge clk);
    chk({ready, access_error}, {1'b1, x});
    chk(rdata, e);
    req.valid = 1'b0;
    @(negedge clk);
  endtask
  // Active flags: written, reserved bits dropped, cleared and set by events
  task automatic t_active();
    acc(2'h3, sw, 12'hD24, 32'h0000_00FF, 32'h0000_0000, 1'b0);
    acc(2'h1, sw, 12'hD24, 32'h0000_0000, 32'h0000_008B, 1'b0);
    active_clr = 4'hF;
    @(negedge clk);
    active_clr = 4'h0;
    chk(active, 4'h0);
    active_set = 4'h8;
    @(negedge clk);
    active_set = 4'h0;
    chk(active, 4'h8);
  endtask
  // Status lanes, write-one-clear, refusals and set beating clear
  task automatic t_status();
    fault.cause_set = 32'h0303_0303;
    @(negedge clk);
    fault.cause_set = 32'h0000_0000;
    acc(2'h1, sw, 12'hD28, 32'h0000_0000, 32'h0303_0303, 1'b0);
    acc(2'h1, sh, 12'hD28, 32'h0000_0000, 32'h0000_0303, 1'b0);
    acc(2'h3, sb, 12'hD29, 32'h0000_0001, 32'h0000_0000, 1'b0);
    acc(2'h3, sh, 12'hD2A, 32'h0000_0102, 32'h0000_0000, 1'b0);
    acc(2'h2, sw, 12'hD28, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    acc(2'h1, sw, 12'hD30, 32'h0000_0000, 32'h0000_0000, 1'b1);
    fault.cause_set = 32'h0000_0001;
    acc(2'h3, sb, 12'hD28, 32'h0000_0001, 32'h0000_0000, 1'b0);
    fault.cause_set = 32'h0000_0000;
    acc(2'h1, sw, 12'hD28, 32'h0000_0000, 32'h0201_0203, 1'b0);
    acc(2'h1, sb, 12'hD29, 32'h0000_0000, 32'h0000_0002, 1'b0);
  endtask
  // Address capture raises both valid flags
  task automatic t_addr();
    fault = '{32'h0000_0000, 1'b1, 32'h2000_0010, 1'b1, 32'h4000_0020};
    @(negedge clk);
    fault = '0;
    chk(memory_fault_address, 32'h2000_0010);
    chk(bus_fault_address, 32'h4000_0020);
    acc(2'h1, sh, 12'hD28, 32'h0000_0000, 32'h0000_8283, 1'b0);
    acc(2'h1, sb, 12'hD28, 32'h0000_0000, 32'h0000_0083, 1'b0);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      summarize();
    end
  end
  // Reset, then the scenarios
  initial begin
    rst = 1'b1;
    {req, fault, active_set, active_clr} = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_active();
    t_status();
    t_addr();
    summarize();
  end
endmodule
`default_nettype wire
